// *** hw/gpcfg_pkg.sv ***
// Purpose: constants for the general pin configuration and chip reset block
// Assumes: byte-wide report stream, one byte per strobe
// Notes:   response record and command layouts as bytes of a 64-byte report
package gpcfg_pkg;
   // ==========================================================
   // report layout
   localparam int unsigned REPORT_LEN      = 64;
   localparam logic [5:0]  PIN0_BYTE       = 6'd22;
   localparam int unsigned PIN_COUNT       = 4;
   localparam logic [5:0]  PWD_FIRST_BYTE  = 6'd17;
   localparam logic [5:0]  PWD_LAST_BYTE   = 6'd21;
   localparam logic [5:0]  PAD_FIRST_BYTE  = 6'd26;
   // ==========================================================
   // settings byte fields
   localparam int unsigned FSEL_LSB        = 0;
   localparam int unsigned DIR_BIT         = 3;
   localparam int unsigned OUTV_BIT        = 4;
   localparam logic [2:0]  FSEL_GPIO       = 3'h0;
   localparam logic [2:0]  FSEL_DEDICATED  = 3'h1;
   localparam logic [2:0]  FSEL_ALT0       = 3'h2;
   localparam logic [2:0]  FSEL_ALT1       = 3'h3;
   localparam logic [2:0]  FSEL_ALT2       = 3'h4;
   localparam logic [7:0]  SETTINGS_RST    = 8'h08;
   localparam logic [7:0]  PAD_VALUE       = 8'h00;
   // ==========================================================
   // chip reset command
   localparam logic [7:0]  CMD_RESET_CHIP  = 8'h70;
   localparam logic [7:0]  KEY_1           = 8'hab;
   localparam logic [7:0]  KEY_2           = 8'hcd;
   localparam logic [7:0]  KEY_3           = 8'hef;
   localparam logic [7:0]  CMD_ZERO        = 8'h00;
   localparam int unsigned RESET_PULSE_CYC = 16;
endpackage : gpcfg_pkg

// *** hw/gpcfg_pin.sv ***
// Purpose: one general pin multiplexer
// Assumes: function code already decoded per pin by the parent
// Notes:   output enable is active low
`timescale 1ns/1ns
module gpcfg_pin
(
   // settings
   input  wire logic [7:0] settings,
   input  wire logic [4:0] alt_out,   // per-code alternate level, bit n for code n
   input  wire logic [4:0] alt_drv,   // code n drives the pin when set
   // pad
   output logic            pin_o,
   output logic            pin_oe_n
);
   // ==========================================================
   // selection
   wire logic [2:0] fsel    = settings[2:0];
   wire logic       is_gpio = (fsel == gpcfg_pkg::FSEL_GPIO);
   wire logic       code_ok = (fsel <= gpcfg_pkg::FSEL_ALT2);
   // plain io: bit 3 direction, bit 4 level; 7..5 ignored
   assign pin_o    = is_gpio ? settings[gpcfg_pkg::OUTV_BIT]
                             : (code_ok ? alt_out[fsel] : 1'b0);
   assign pin_oe_n = is_gpio ? settings[gpcfg_pkg::DIR_BIT]
                             : ~(code_ok & alt_drv[fsel]);
endmodule : gpcfg_pin

// *** hw/gpcfg_top.sv ***
// Purpose: pin configuration record, pin mux, response builder, chip reset
// Assumes: command bytes arrive one per strobe, first byte flagged
// Notes:   analog pins are released (input) at the pad
`timescale 1ns/1ns
module gpcfg_top
#(
   parameter int unsigned PINS = 4
)
(
   // clock and reset
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic            clk_en,
   // command stream
   input  wire logic            cmd_valid,
   input  wire logic            cmd_first,
   input  wire logic [7:0]      cmd_byte,
   // settings load and password
   input  wire logic            cfg_we,
   input  wire logic [1:0]      cfg_pin,
   input  wire logic [7:0]      cfg_data,
   input  wire logic [39:0]     password_hi,
   // response readout
   input  wire logic            resp_req,
   input  wire logic [5:0]      resp_idx,
   output logic                 resp_valid_r,
   output logic [7:0]           resp_byte_r,
   // dedicated function sources
   input  wire logic            suspend_indicator,
   input  wire logic            receive_activity_lamp,
   input  wire logic            clock_ref,
   input  wire logic            transmit_activity_lamp,
   input  wire logic            enumeration_done_indicator,
   input  wire logic            serial_bus_activity_lamp,
   // pads and reset request
   output logic [PINS-1:0]      general_pin_o_r,
   output logic [PINS-1:0]      general_pin_oe_n_r,
   output logic                 chip_reset_r
);
   // ==========================================================
   // stored settings
   logic [7:0]           settings_r [PINS];
   wire logic [PINS-1:0] pin_o_w;
   wire logic [PINS-1:0] pin_oe_n_w;

   // command matcher state, declared early: the response gate reads it
   typedef enum {GPCFG_IDLE, GPCFG_MATCH, GPCFG_FIRE} gpcfg_state_t;
   gpcfg_state_t         state_r;
   logic [5:0]           pos_r;
   logic                 busy_rst_r;
   logic [4:0]           pulse_r;

   // alternate sources per pin and code; analog codes never drive
   wire logic [4:0] src0 = {2'h0, receive_activity_lamp, suspend_indicator, 1'b0};
   wire logic [4:0] src1 = {1'b0, transmit_activity_lamp, 1'b0, clock_ref, 1'b0};
   wire logic [4:0] src2 = {3'h0, enumeration_done_indicator, 1'b0};
   wire logic [4:0] src3 = {3'h0, serial_bus_activity_lamp, 1'b0};
   wire logic [4:0] drv0 = 5'h06;
   wire logic [4:0] drv1 = 5'h0a;   // edge detect is an input
   wire logic [4:0] drv2 = 5'h02;   // analog out: pad released to the analog cell
   wire logic [4:0] drv3 = 5'h02;
   wire logic [4:0] srcs [4] = '{src0, src1, src2, src3};
   wire logic [4:0] drvs [4] = '{drv0, drv1, drv2, drv3};

   genvar g;
   generate
      for (g = 0; g < PINS; g++)
      begin : g_pin
         // settings load, one byte per pin
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               settings_r[g] <= gpcfg_pkg::SETTINGS_RST;
            else if (clk_en && cfg_we && cfg_pin == 2'(g))
               settings_r[g] <= cfg_data;
         end
         gpcfg_pin u_pin
         (
            .settings (settings_r[g]),
            .alt_out  (srcs[g]),
            .alt_drv  (drvs[g]),
            .pin_o    (pin_o_w[g]),
            .pin_oe_n (pin_oe_n_w[g])
         );
      end
   endgenerate

   // registered pad outputs; input after reset
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         general_pin_o_r    <= '0;
         general_pin_oe_n_r <= '1;
      end
      else if (clk_en)
      begin
         general_pin_o_r    <= pin_o_w;
         general_pin_oe_n_r <= pin_oe_n_w;
      end
   end

   // ==========================================================
   // response record readout
   wire logic       idx_pwd  = (resp_idx >= gpcfg_pkg::PWD_FIRST_BYTE) &&
                               (resp_idx <= gpcfg_pkg::PWD_LAST_BYTE);
   wire logic [5:0] pwd_off  = resp_idx - gpcfg_pkg::PWD_FIRST_BYTE;
   wire logic [5:0] pin_off  = resp_idx - gpcfg_pkg::PIN0_BYTE;
   wire logic       idx_pin  = (resp_idx >= gpcfg_pkg::PIN0_BYTE) &&
                               (resp_idx < gpcfg_pkg::PAD_FIRST_BYTE);
   wire logic [7:0] resp_nxt;
   assign resp_nxt = idx_pwd ? password_hi[pwd_off[2:0]*8 +: 8]
                   : idx_pin ? settings_r[pin_off[1:0]]
                   : gpcfg_pkg::PAD_VALUE;

   // a request during a reset command is not answered
   wire logic resp_ok = resp_req && !chip_reset_r && !busy_rst_r;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         resp_valid_r <= 1'b0;
         resp_byte_r  <= '0;
      end
      else if (clk_en)
      begin
         resp_valid_r <= resp_ok;
         if (resp_ok)
            resp_byte_r <= resp_nxt;
      end
   end

   // ==========================================================
   // reset chip command matcher

   // expected byte at each position
   wire logic [7:0] expect_b = (pos_r == 6'd1) ? gpcfg_pkg::KEY_1
                             : (pos_r == 6'd2) ? gpcfg_pkg::KEY_2
                             : (pos_r == 6'd3) ? gpcfg_pkg::KEY_3
                             : gpcfg_pkg::CMD_ZERO;
   wire logic last_b   = (pos_r == 6'(gpcfg_pkg::REPORT_LEN - 1));
   wire logic start_b  = cmd_valid && cmd_first && cmd_byte == gpcfg_pkg::CMD_RESET_CHIP;

   // a mismatch drops the whole report; a partial key never resets
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_r      <= GPCFG_IDLE;
         pos_r        <= '0;
         busy_rst_r   <= 1'b0;
         pulse_r      <= '0;
         chip_reset_r <= 1'b0;
      end
      else if (clk_en)
      begin
         case (state_r)
            GPCFG_IDLE:
            begin
               if (start_b)
               begin
                  state_r    <= GPCFG_MATCH;
                  pos_r      <= 6'd1;
                  busy_rst_r <= 1'b1;
               end
            end
            GPCFG_MATCH:
            begin
               if (cmd_valid && (cmd_first || cmd_byte != expect_b))
               begin
                  state_r    <= GPCFG_IDLE;
                  busy_rst_r <= 1'b0;
               end
               else if (cmd_valid && last_b)
               begin
                  state_r      <= GPCFG_FIRE;
                  chip_reset_r <= 1'b1;
                  pulse_r      <= 5'(gpcfg_pkg::RESET_PULSE_CYC - 1);
               end
               else if (cmd_valid)
                  pos_r <= pos_r + 6'd1;
            end
            GPCFG_FIRE:
            begin
               // held a fixed time; outer reset network restarts the chip
               if (pulse_r == '0)
               begin
                  chip_reset_r <= 1'b0;
                  busy_rst_r   <= 1'b0;
                  state_r      <= GPCFG_IDLE;
               end
               else
                  pulse_r <= pulse_r - 5'd1;
            end
            default:
               state_r <= GPCFG_IDLE;
         endcase
      end
   end

   // ==========================================================
   // checks
   a_out_level: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && settings_r[0][2:0] == 3'h0 && !settings_r[0][3]
      |=> general_pin_o_r[0] == $past(settings_r[0][4]) && !general_pin_oe_n_r[0])
      else $error("plain output level wrong");
   a_dir_input: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && settings_r[1][2:0] == 3'h0 && settings_r[1][3] |=> general_pin_oe_n_r[1])
      else $error("input pin driven");
   a_pin0_susp: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && settings_r[0][2:0] == 3'h1
      |=> general_pin_o_r[0] == $past(suspend_indicator) && !general_pin_oe_n_r[0])
      else $error("suspend not routed");
   a_pin1_tx: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && settings_r[1][2:0] == 3'h3
      |=> general_pin_o_r[1] == $past(transmit_activity_lamp))
      else $error("transmit lamp not routed");
   a_pin2_enum: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && settings_r[2][2:0] == 3'h1
      |=> general_pin_o_r[2] == $past(enumeration_done_indicator))
      else $error("enumeration flag not routed");
   a_pin3_adc: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && settings_r[3][2:0] == 3'h2 |=> general_pin_oe_n_r[3])
      else $error("analog input pin driven");
   a_pad_zero: assert property (@(posedge clk_sys) disable iff (rst)
      clk_en && resp_ok && resp_idx >= 6'd26 |=> resp_byte_r == 8'h00)
      else $error("padding not zero");
   a_reset_fire: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(chip_reset_r) |-> chip_reset_r [*8])
      else $error("reset pulse short");
   a_no_reply: assert property (@(posedge clk_sys) disable iff (rst)
      chip_reset_r |-> ##1 !resp_valid_r)
      else $error("reply during reset");
endmodule : gpcfg_top

// *** tb/gpcfg_host.sv ***
// Purpose: host side model that sends 64-byte command reports
// Assumes: one byte per clock, driven just after the rising edge
// Notes:   idle byte lane shows the inverse of its last value
`timescale 1ns/1ns
module gpcfg_host
(
   // clock
   input  wire logic  clk_sys,
   // command stream
   output logic       cmd_valid,
   output logic       cmd_first,
   output logic [7:0] cmd_byte
);
   // =====================================================
   // idle state
   initial
   begin
      cmd_valid = 1'b0;
      cmd_first = 1'b0;
      cmd_byte  = 8'h00;
   end

   // one reset report; bad_pos in 1..63 spoils that byte, -1 sends it whole
   task automatic send(input int bad_pos);
      logic [7:0] b;
      for (int i = 0; i < 64; i++)
      begin
         case (i)
            0:       b = gpcfg_pkg::CMD_RESET_CHIP;
            1:       b = gpcfg_pkg::KEY_1;
            2:       b = gpcfg_pkg::KEY_2;
            3:       b = gpcfg_pkg::KEY_3;
            default: b = gpcfg_pkg::CMD_ZERO;
         endcase
         if (i == bad_pos)
            b = b ^ 8'h01;
         @(posedge clk_sys);
         cmd_valid <= 1'b1;
         cmd_first <= (i == 0);
         cmd_byte  <= b;
      end
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      cmd_first <= 1'b0;
      cmd_byte  <= ~b;   // stale data must not pass for a held byte
   endtask : send
endmodule : gpcfg_host

// *** tb/tb_gpcfg_top.sv ***
// Purpose: self-checking bench for the pin mux and chip reset block
// Assumes: 125 MHz clock, sync active-high reset held 16 cycles
// Notes:   pseudo-random stimulus from an lfsr seeded with 66
`timescale 1ns/1ns
module tb_gpcfg_top;
   logic        clk_sys, rst, clk_en, cmd_valid, cmd_first, cfg_we, resp_req;
   logic        resp_valid_r, chip_reset_r, v;
   logic [7:0]  cmd_byte, cfg_data, resp_byte_r, rnd, d, keep;
   logic [7:0]  sh [4];
   logic [1:0]  cfg_pin, e;
   logic [5:0]  resp_idx, src;
   logic [39:0] password_hi;
   logic [3:0]  general_pin_o_r, general_pin_oe_n_r;
   int          err_total, checked, n, c, vb;

   gpcfg_top uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cmd_valid(cmd_valid),
      .cmd_first(cmd_first), .cmd_byte(cmd_byte), .cfg_we(cfg_we), .cfg_pin(cfg_pin),
      .cfg_data(cfg_data), .password_hi(password_hi), .resp_req(resp_req),
      .resp_idx(resp_idx), .resp_valid_r(resp_valid_r), .resp_byte_r(resp_byte_r),
      .suspend_indicator(src[0]), .receive_activity_lamp(src[1]), .clock_ref(src[2]),
      .transmit_activity_lamp(src[3]), .enumeration_done_indicator(src[4]),
      .serial_bus_activity_lamp(src[5]), .general_pin_o_r(general_pin_o_r),
      .general_pin_oe_n_r(general_pin_oe_n_r), .chip_reset_r(chip_reset_r));
   gpcfg_host host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
      .cmd_byte(cmd_byte));

   // =====================================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // expected {oe_n, level}; unlisted codes release the pad
   function automatic logic [1:0] pexp(input logic [1:0] p, input logic [7:0] s);
      case ({p, s[2:0]})
         5'h00, 5'h08, 5'h10, 5'h18: return s[3] ? 2'h2 : {1'b0, s[4]};
         5'h01:   return {1'b0, src[0]};
         5'h02:   return {1'b0, src[1]};
         5'h09:   return {1'b0, src[2]};
         5'h0b:   return {1'b0, src[3]};
         5'h11:   return {1'b0, src[4]};
         5'h19:   return {1'b0, src[5]};
         default: return 2'h2;
      endcase
   endfunction : pexp

   function automatic logic [7:0] rexp(input logic [5:0] i);
      if (i >= 6'h11 && i <= 6'h15)
         return password_hi[(i - 6'h11) * 8 +: 8];
      if (i >= 6'h16 && i <= 6'h19)
         return sh[i - 6'h16];
      return gpcfg_pkg::PAD_VALUE;
   endfunction : rexp

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [1:0] p, input logic [7:0] dat);
      @(posedge clk_sys);
      cfg_we   <= 1'b1;
      cfg_pin  <= p;
      cfg_data <= dat;
      @(posedge clk_sys);
      cfg_we   <= 1'b0;
      sh[p] = dat;
   endtask : wr

   task automatic rd(input logic [5:0] i);
      @(posedge clk_sys);
      resp_req <= 1'b1;
      resp_idx <= i;
      @(posedge clk_sys);
      resp_req <= 1'b0;
      #1;
      v = resp_valid_r;
      d = resp_byte_r;
   endtask : rd

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   // =====================================================
   // clock and watchdog; whole run needs about 710 cycles
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (6000) @(posedge clk_sys);
      err_total++;
      summarize();
   end

   // =====================================================
   // main sequence
   initial
   begin
      rst = 1'b1; clk_en = 1'b1; cfg_we = 1'b0; cfg_pin = 2'h0; cfg_data = 8'h00;
      resp_req = 1'b0; resp_idx = 6'h00; src = 6'h00; password_hi = 40'h0; rnd = 8'h42;
      for (n = 0; n < 4; n++)
         sh[n] = gpcfg_pkg::SETTINGS_RST;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk({4'h0, general_pin_oe_n_r}, 8'h0f);
      chk({7'h00, chip_reset_r}, 8'h00);
      $display("test reset state done");
      // every code on every pin, random direction, level and ignored bits
      for (n = 0; n < 32; n++)
      begin
         rnd = lfsr(rnd);
         @(posedge clk_sys);
         src         <= rnd[5:0];
         password_hi <= {password_hi[31:0], rnd};
         wr(n[4:3], {rnd[7:3], n[2:0]});
         repeat (2) @(posedge clk_sys);
         #1;
         e = pexp(n[4:3], sh[n[4:3]]);
         chk({7'h00, general_pin_oe_n_r[n[4:3]]}, {7'h00, e[1]});
         if (e[1] === 1'b0)
            chk({7'h00, general_pin_o_r[n[4:3]]}, {7'h00, e[0]});
      end
      $display("test pin mux done");
      // frozen clock enable: neither a write nor a source change may land
      keep = sh[0];
      d    = {general_pin_oe_n_r, general_pin_o_r};
      @(posedge clk_sys);
      clk_en <= 1'b0;
      src    <= ~src;
      wr(2'h0, ~keep);
      sh[0] = keep;
      repeat (2) @(posedge clk_sys);
      #1;
      chk({general_pin_oe_n_r, general_pin_o_r}, d);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      $display("test clock enable done");
      // full record readback, padding included
      for (n = 0; n < 64; n++)
      begin
         rd(n[5:0]);
         chk({7'h00, v}, 8'h01);
         chk(d, rexp(n[5:0]));
      end
      $display("test record readback done");
      // spoiled keys or padding must not reset
      for (n = 0; n < 2; n++)
      begin
         rnd = lfsr(rnd);
         host.send(n == 0 ? 3 : 4 + int'(rnd[5:0]) % 60);
         c = 0;
         repeat (90)
         begin
            @(posedge clk_sys);
            #1;
            c += (chip_reset_r === 1'b1);
         end
         chk(c[7:0], 8'h00);
      end
      $display("test spoiled reset done");
      // good report: one pulse, no reply while it runs
      host.send(-1);
      c = 0;
      vb = 0;
      // sample from the edge that raised the pulse, so all of it is counted
      repeat (24)
      begin
         #1;
         c += (chip_reset_r === 1'b1);
         vb += (chip_reset_r === 1'b1 && resp_valid_r !== 1'b0);
         @(posedge clk_sys);
         resp_req <= 1'b1;
      end
      chk(c[7:0], 8'(gpcfg_pkg::RESET_PULSE_CYC));
      chk(vb[7:0], 8'h00);
      // answers resume once the pulse has ended
      rd(6'h16);
      chk({7'h00, v}, 8'h01);
      chk(d, rexp(6'h16));
      $display("test chip reset done");
      summarize();
   end
endmodule : tb_gpcfg_top
